//--- verilog/pfl_pwm12_fault_lock_unit.sv
// Purpose: 12-bit pwm, complementary output, fault shutdown, write lock
// Assumes: axi4-lite master holds valid and payload until taken
// Notes: everything runs on clock_i and freezes while ce_i is low
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module pfl_pwm12_fault_lock_unit
  import pfl_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic fault_input_i,
  output logic main_output_o,
  output logic complementary_output_o,
  output logic main_pin_sel_o,
  output logic comp_pin_sel_o,
  output logic period_irq_o
);

  // ********************************
  // decode helper
  // ********************************
  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (idx == IDX_OUTPUT_GATE) || (idx == IDX_MODULE_ENABLE) ||
      (idx == IDX_CONTROL) || (idx == IDX_PERIOD_LOW) ||
      (idx == IDX_PERIOD_HIGH) || (idx == IDX_DUTY_LOW) ||
      (idx == IDX_DUTY_HIGH) || (idx == IDX_WRITE_LOCK) ||
      (idx == IDX_IRQ_ENABLE_TWO);
  endfunction : is_mapped

  // ********************************
  // axi write channel
  // ********************************
  logic aw_full_reg;
  logic w_full_reg;
  logic [7:0] aw_idx_reg;
  logic [7:0] w_data_reg;
  logic w_lane_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic do_write;
  logic key_ok;

  assign s_axi_awready_o = !aw_full_reg && !bvalid_reg && ce_i;
  assign s_axi_wready_o = !w_full_reg && !bvalid_reg && ce_i;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  // both halves held: commit in one cycle, response the next
  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg && ce_i;

  // address and data are captured independently, in either order
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_idx_reg <= RST_BYTE;
      w_data_reg <= RST_BYTE;
      w_lane_reg <= 1'b0;
    end else if (ce_i) begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_full_reg <= 1'b1;
        aw_idx_reg <= s_axi_awaddr_i[ADDR_W-1:2];
      end else if (do_write) begin
        aw_full_reg <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i[7:0];
        w_lane_reg <= s_axi_wstrb_i[0];
      end else if (do_write) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  // write response, slverr for an index nobody owns
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (ce_i) begin
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= is_mapped(aw_idx_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ********************************
  // software registers
  // ********************************
  logic [7:0] lock_reg;
  logic gate_reg;
  logic fault_en_reg;
  logic comp_en_reg;
  logic main_en_reg;
  logic irq_en_reg;
  logic irq_flag_reg;
  logic fault_st_reg;
  logic fault_lvl_reg;
  logic pol_reg;
  logic [1:0] pscl_reg;
  logic [11:0] period_reg;
  logic [11:0] duty_reg;
  logic global_en_reg;
  logic wr_lane;
  logic boundary;
  logic fault_active;

  assign wr_lane = do_write && w_lane_reg;
  assign key_ok = (lock_reg == LOCK_KEY);

  // the lock itself and the output gate are never locked
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lock_reg <= RST_BYTE;
      gate_reg <= 1'b0;
      global_en_reg <= 1'b0;
    end else if (ce_i && wr_lane) begin
      if (aw_idx_reg == IDX_WRITE_LOCK) begin
        lock_reg <= w_data_reg;
      end
      if (aw_idx_reg == IDX_OUTPUT_GATE) begin
        gate_reg <= w_data_reg[BIT_GATE];
      end
      if (aw_idx_reg == IDX_IRQ_ENABLE_TWO) begin
        global_en_reg <= w_data_reg[BIT_GLOBAL_EN];
      end
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fault_en_reg <= 1'b0;
      comp_en_reg <= 1'b0;
      main_en_reg <= 1'b0;
      irq_en_reg <= 1'b0;
      fault_lvl_reg <= 1'b0;
      pol_reg <= 1'b0;
      pscl_reg <= 2'b00;
    end else if (ce_i && wr_lane && key_ok) begin
      if (aw_idx_reg == IDX_MODULE_ENABLE) begin
        fault_en_reg <= w_data_reg[BIT_FAULT_EN];
        comp_en_reg <= w_data_reg[BIT_COMP_EN];
        main_en_reg <= w_data_reg[BIT_MAIN_EN];
      end
      if (aw_idx_reg == IDX_CONTROL) begin
        irq_en_reg <= w_data_reg[BIT_IRQ_EN];
        fault_lvl_reg <= w_data_reg[BIT_FAULT_LVL];
        pol_reg <= w_data_reg[BIT_POLARITY];
        pscl_reg <= w_data_reg[1:0];
      end
    end
  end

  // period and duty bytes, low then high
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      period_reg <= RST_VALUE12;
      duty_reg <= RST_VALUE12;
    end else if (ce_i && wr_lane && key_ok) begin
      unique case (aw_idx_reg)
        IDX_PERIOD_LOW: period_reg[7:0] <= w_data_reg;
        IDX_PERIOD_HIGH: period_reg[11:8] <= w_data_reg[3:0];
        IDX_DUTY_LOW: duty_reg[7:0] <= w_data_reg;
        IDX_DUTY_HIGH: duty_reg[11:8] <= w_data_reg[3:0];
        default: ;
      endcase
    end
  end

  // status flags: a hardware set in the same cycle beats the clear
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_flag_reg <= 1'b0;
      fault_st_reg <= 1'b0;
    end else if (ce_i) begin
      if (boundary) begin
        irq_flag_reg <= 1'b1;
      end else if (wr_lane && key_ok && aw_idx_reg == IDX_CONTROL &&
                   !w_data_reg[BIT_IRQ_FLAG]) begin
        irq_flag_reg <= 1'b0;
      end
      // fault status sticks while fault is live
      if (fault_active) begin
        fault_st_reg <= 1'b1;
      end else if (wr_lane && key_ok && aw_idx_reg == IDX_CONTROL &&
                   !w_data_reg[BIT_FAULT_ST]) begin
        fault_st_reg <= 1'b0;
      end
    end
  end

  // ********************************
  // axi read channel
  // ********************************
  logic rvalid_reg;
  logic [7:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [7:0] rd_idx;
  logic [7:0] rd_byte;

  assign s_axi_arready_o = !rvalid_reg && ce_i;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = {24'h000000, rdata_reg};
  assign s_axi_rresp_o = rresp_reg;
  assign rd_idx = s_axi_araddr_i[ADDR_W-1:2];

  // read mux, reserved bits and unmapped words read zero
  always_comb begin
    rd_byte = RST_BYTE;
    unique case (rd_idx)
      IDX_OUTPUT_GATE: rd_byte = {7'h00, gate_reg};
      IDX_MODULE_ENABLE: rd_byte = {1'b0, fault_en_reg, 2'b00,
        comp_en_reg, 2'b00, main_en_reg};
      IDX_CONTROL: rd_byte = {irq_en_reg, irq_flag_reg, 1'b0,
        fault_st_reg, fault_lvl_reg, pol_reg, pscl_reg};
      IDX_PERIOD_LOW: rd_byte = period_reg[7:0];
      IDX_PERIOD_HIGH: rd_byte = {4'h0, period_reg[11:8]};
      IDX_DUTY_LOW: rd_byte = duty_reg[7:0];
      IDX_DUTY_HIGH: rd_byte = {4'h0, duty_reg[11:8]};
      IDX_WRITE_LOCK: rd_byte = lock_reg;
      IDX_IRQ_ENABLE_TWO: rd_byte = {7'h00, global_en_reg};
      default: rd_byte = RST_BYTE;
    endcase
  end

  // one read outstanding; data held until rready
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= RST_BYTE;
      rresp_reg <= RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_byte;
        rresp_reg <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready_i) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ********************************
  // fault pin
  // ********************************
  logic fault_sync1_reg;
  logic fault_sync2_reg;

  // pin is asynchronous; only the second stage is read
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fault_sync1_reg <= 1'b0;
      fault_sync2_reg <= 1'b0;
    end else if (ce_i) begin
      fault_sync1_reg <= fault_input_i;
      fault_sync2_reg <= fault_sync1_reg;
    end
  end

  assign fault_active = fault_en_reg &&
    (fault_sync2_reg == fault_lvl_reg);

  // ********************************
  // modulator timing
  // ********************************
  logic running;
  logic [3:0] pre_cnt_reg;
  logic [3:0] pre_last;
  logic tick;
  logic [11:0] cnt_reg;
  logic [11:0] per_w_reg;
  logic [11:0] duty_w_reg;
  logic pol_w_reg;
  logic [1:0] pscl_w_reg;

  // the gate register does not stop the timer
  assign running = main_en_reg || comp_en_reg;
  // divide by 2, 4, 8, 16
  assign pre_last = 4'((5'd2 << pscl_w_reg) - 5'd1);
  assign tick = running && (pre_cnt_reg == pre_last);
  // period end; a zero period ends every modulator clock
  assign boundary = tick &&
    ((per_w_reg == RST_VALUE12) || (cnt_reg == per_w_reg - 12'd1));

  // prescaler restarts whenever the module is disabled
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pre_cnt_reg <= 4'h0;
    end else if (ce_i) begin
      if (!running || tick) begin
        pre_cnt_reg <= 4'h0;
      end else begin
        pre_cnt_reg <= pre_cnt_reg + 4'h1;
      end
    end
  end

  // working copies reload only at a boundary or while idle
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_reg <= RST_VALUE12;
      per_w_reg <= RST_VALUE12;
      duty_w_reg <= RST_VALUE12;
      pol_w_reg <= 1'b0;
      pscl_w_reg <= 2'b00;
    end else if (ce_i) begin
      if (!running || boundary) begin
        cnt_reg <= RST_VALUE12;
        per_w_reg <= period_reg;
        duty_w_reg <= duty_reg;
        pol_w_reg <= pol_reg;
        pscl_w_reg <= pscl_reg;
      end else if (tick) begin
        cnt_reg <= cnt_reg + 12'd1;
      end
    end
  end

  // ********************************
  // output stage
  // ********************************
  logic active_c;
  logic main_c;
  logic comp_c;
  logic main_q_reg;
  logic comp_q_reg;
  logic irq_q_reg;

  always_comb begin
    if (per_w_reg == RST_VALUE12) begin
      active_c = 1'b0;
    end else if (per_w_reg <= duty_w_reg) begin
      active_c = 1'b1;
    end else begin
      active_c = (cnt_reg < duty_w_reg);
    end
  end

  always_comb begin
    if (fault_st_reg || fault_active) begin
      main_c = pol_w_reg;
      comp_c = pol_w_reg;
    end else begin
      main_c = active_c ^ pol_w_reg;
      comp_c = ~main_c;
    end
  end

  // registered pins; fault reaches them one edge after the sync
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      main_q_reg <= 1'b0;
      comp_q_reg <= 1'b0;
      irq_q_reg <= 1'b0;
    end else if (ce_i) begin
      main_q_reg <= main_c;
      comp_q_reg <= comp_c;
      irq_q_reg <= irq_flag_reg && irq_en_reg && global_en_reg;
    end
  end

  assign main_output_o = main_q_reg;
  assign complementary_output_o = comp_q_reg;
  // pin ownership, dropped at once on disable or gate
  assign main_pin_sel_o = main_en_reg && !gate_reg;
  assign comp_pin_sel_o = comp_en_reg && !gate_reg;
  assign period_irq_o = irq_q_reg;

endmodule : pfl_pwm12_fault_lock_unit

//--- verilog/pfl_pkg.sv
// Purpose: shared constants for the 12-bit pwm with fault lock
// Assumes: register index times four gives the axi byte address
// Notes: all registers are eight bits wide, in the low byte of a word
package pfl_pkg;
  // ********************************
  // register indices
  // ********************************
  localparam logic [7:0] IDX_OUTPUT_GATE = 8'hb7;
  localparam logic [7:0] IDX_MODULE_ENABLE = 8'hcf;
  localparam logic [7:0] IDX_CONTROL = 8'hd2;
  localparam logic [7:0] IDX_PERIOD_LOW = 8'hd3;
  localparam logic [7:0] IDX_PERIOD_HIGH = 8'hd4;
  localparam logic [7:0] IDX_DUTY_LOW = 8'hd5;
  localparam logic [7:0] IDX_DUTY_HIGH = 8'hd6;
  localparam logic [7:0] IDX_WRITE_LOCK = 8'he7;
  localparam logic [7:0] IDX_IRQ_ENABLE_TWO = 8'hf8;
  localparam int ADDR_W = 10;
  // ********************************
  // field positions
  // ********************************
  localparam int BIT_FAULT_EN = 6;
  localparam int BIT_COMP_EN = 3;
  localparam int BIT_MAIN_EN = 0;
  localparam int BIT_GATE = 0;
  localparam int BIT_IRQ_EN = 7;
  localparam int BIT_IRQ_FLAG = 6;
  localparam int BIT_FAULT_ST = 4;
  localparam int BIT_FAULT_LVL = 3;
  localparam int BIT_POLARITY = 2;
  localparam int BIT_GLOBAL_EN = 0;
  // ********************************
  // values after reset and key
  // ********************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [11:0] RST_VALUE12 = 12'h000;
  localparam logic [7:0] LOCK_KEY = 8'h55;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : pfl_pkg

//--- verification/pfl_unit_properties.sv
// Purpose: bus handshake checks at the pwm unit ports
// Assumes: ce_i is held high, so every ready is live
// Notes: waveform and fault timing are judged by the bench model
`timescale 1ns/100ps
module pfl_unit_properties
  import pfl_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  logic ar_ok;
  logic ar_go;
  // ************************************
  // decode and handshake checks
  // ************************************
  // read index hits one of the mapped registers
  assign ar_ok = s_axi_araddr_i[9:2] inside {IDX_OUTPUT_GATE,
    IDX_MODULE_ENABLE, IDX_CONTROL, IDX_PERIOD_LOW, IDX_PERIOD_HIGH,
    IDX_DUTY_LOW, IDX_DUTY_HIGH, IDX_WRITE_LOCK, IDX_IRQ_ENABLE_TWO};
  assign ar_go = s_axi_arvalid_i && s_axi_arready_o;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  property p_b_hold;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bresp dropped");
  property p_r_hold;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rdata dropped");
  property p_w_lat;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      |-> ##[2:3] s_axi_bvalid_o;
  endproperty
  a_w_lat: assert property (p_w_lat) else $error("write answer late");
  property p_r_lat;
    ar_go |=> s_axi_rvalid_o;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_unmapped;
    ar_go && !ar_ok |=> s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("bad unmapped read");
  property p_mapped;
    ar_go && ar_ok |=> s_axi_rresp_o == RESP_OKAY && s_axi_rdata_o[31:8] == 24'h0;
  endproperty
  a_mapped: assert property (p_mapped) else $error("bad mapped read");
  property p_b_refuse;
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
  endproperty
  a_b_refuse: assert property (p_b_refuse) else $error("write taken early");
  property p_r_refuse;
    s_axi_rvalid_o |-> !s_axi_arready_o;
  endproperty
  a_r_refuse: assert property (p_r_refuse) else $error("read taken early");
endmodule : pfl_unit_properties

bind pfl_pwm12_fault_lock_unit pfl_unit_properties u_props (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i));

//--- verification/pfl_power_stage_model.sv
// Purpose: power stage that reports an overload on the fault line
// Assumes: the bench commands when a fault occurs
// Notes: the line is always driven, it has no pull resistor
`timescale 1ns/100ps
module pfl_power_stage_model (
  input wire logic clock_i,
  input wire logic trip_i,
  input wire logic trip_high_i,
  output logic fault_o
);
  always_ff @(posedge clock_i) begin
    fault_o <= trip_i ? trip_high_i : !trip_high_i;
  end
endmodule : pfl_power_stage_model

//--- verification/tb_pwm12_fault_lock_unit.sv
// Purpose: self-checking bench for the 12-bit pwm unit
// Assumes: ce_i tied high, 125 MHz clock
// Notes: expected waveforms come from exp_hi, not from the design
`timescale 1ns/100ps
module tb_pwm12_fault_lock_unit
  import pfl_pkg::*;
;
  logic clock_i, sys_rst_i, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, mo, co, ms, cs, irq;
  logic trip, trip_hi, fault;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  int err_count, n_tests;
  pfl_pwm12_fault_lock_unit dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .ce_i(1'b1), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .fault_input_i(fault), .main_output_o(mo),
    .complementary_output_o(co), .main_pin_sel_o(ms), .comp_pin_sel_o(cs),
    .period_irq_o(irq));
  pfl_power_stage_model u_stage (.clock_i(clock_i), .trip_i(trip),
    .trip_high_i(trip_hi), .fault_o(fault));
  // ************************************
  // clock, helpers and bus tasks
  // ************************************
  // free running 8 ns clock
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  // longest path is about 5k cycles, so 60k cannot be reached normally
  initial begin
    repeat (60000) @(posedge clock_i);
    err_count++;
    finish_test();
  end
  task automatic finish_test();
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // active cycles in one window; zero period idles, p <= d saturates
  function automatic int exp_hi(int p, int dd, int ps, bit pol, int win);
    int act;
    act = (p == 0) ? 0 : (p <= dd) ? win : dd * (2 << ps);
    return pol ? win - act : act;
  endfunction : exp_hi
  // response ready goes up with the request and stays until the answer
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    bit a, w;
    a = 0;
    w = 0;
    @(posedge clock_i);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, v};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(a && w)) begin
      @(posedge clock_i);
      if (awvalid && awready) begin a = 1; awvalid <= 1'b0; end
      if (wvalid && wready) begin w = 1; wvalid <= 1'b0; end
    end
    do @(posedge clock_i); while (!bvalid);
    check(34'(bresp), 34'(RESP_OKAY));
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] idx);
    @(posedge clock_i);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock_i); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clock_i); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic wave(input int n, output int hi, output int bad,
                      output int iq);
    hi = 0;
    bad = 0;
    iq = 0;
    repeat (n) begin
      @(posedge clock_i);
      #1;
      hi += (mo === 1'b1);
      bad += (co !== !mo);
      iq += (irq === 1'b1);
    end
  endtask : wave
  // ************************************
  // main sequence
  // ************************************
  initial begin
    int p, dd, ps, win, hi, bad, iq, e;
    bit pol;
    logic [7:0] ridx [5];
    ridx = '{IDX_OUTPUT_GATE, IDX_MODULE_ENABLE, IDX_CONTROL,
             IDX_PERIOD_LOW, IDX_WRITE_LOCK};
    {awvalid, wvalid, bready, arvalid, rready, trip} = 6'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    trip_hi = 1'b1;
    seed = 32'he6a33054;
    sys_rst_i = 1'b1;
    repeat (6) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    foreach (ridx[i]) begin
      rd(ridx[i]);
      check({r, d}, {RESP_OKAY, 32'h0});
    end
    rd(8'h10);
    check({r, d}, {RESP_SLVERR, 32'h0});
    wr(IDX_PERIOD_LOW, 8'ha5);
    rd(IDX_PERIOD_LOW);
    check(34'(d), 34'h0);
    wr(IDX_WRITE_LOCK, LOCK_KEY);
    wr(IDX_PERIOD_LOW, 8'ha5);
    rd(IDX_PERIOD_LOW);
    check(34'(d), 34'ha5);
    $display("register test done");
    wr(IDX_IRQ_ENABLE_TWO, 8'h01);
    for (int k = 0; k < 8; k++) begin
      ps = k % 4;
      pol = k / 4;
      p = 3 + int'(rnd() % 6);
      dd = 1 + int'(rnd() % (p - 1));
      if (k == 2) p = 0;
      if (k == 5) dd = p + 1;
      win = (p == 0) ? 32 : p * (2 << ps);
      // low byte first, then high byte
      wr(IDX_PERIOD_LOW, p[7:0]);
      wr(IDX_PERIOD_HIGH, 8'h00);
      wr(IDX_DUTY_LOW, dd[7:0]);
      wr(IDX_DUTY_HIGH, 8'h00);
      wr(IDX_CONTROL, {5'h0, pol, ps[1:0]});
      wr(IDX_MODULE_ENABLE, 8'h09);
      repeat (300) @(posedge clock_i);
      wave(win, hi, bad, iq);
      check(34'(hi), 34'(exp_hi(p, dd, ps, pol, win)));
      check(34'(bad), 34'h0);
      check({ms, cs}, 34'h3);
    end
    $display("waveform test done");
    e = exp_hi(p, dd, ps, pol, win);
    wr(IDX_CONTROL, 8'h07);
    wave(2 * win, hi, bad, iq);
    check(34'(iq), 34'h0);
    rd(IDX_CONTROL);
    check(34'(d[6]), 34'h1);
    wr(IDX_CONTROL, 8'h87);
    wave(2 * win, hi, bad, iq);
    check(34'(iq > 0), 34'h1);
    wr(IDX_IRQ_ENABLE_TWO, 8'h00);
    wave(2 * win, hi, bad, iq);
    check(34'(iq), 34'h0);
    $display("interrupt test done");
    wr(IDX_OUTPUT_GATE, 8'h01);
    check({ms, cs}, 34'h0);
    wr(IDX_CONTROL, 8'h07);
    repeat (300) @(posedge clock_i);
    rd(IDX_CONTROL);
    check(34'(d[6]), 34'h1);
    wr(IDX_OUTPUT_GATE, 8'h00);
    check({ms, cs}, 34'h3);
    $display("gate test done");
    @(posedge clock_i);
    trip <= 1'b1;
    wr(IDX_CONTROL, 8'h0f);
    wave(win, hi, bad, iq);
    check(34'(hi), 34'(e));
    wr(IDX_MODULE_ENABLE, 8'h49);
    wave(win, hi, bad, iq);
    check(34'(hi), 34'(win));
    check(34'(bad), 34'(win));
    rd(IDX_CONTROL);
    check(34'(d[4]), 34'h1);
    wr(IDX_CONTROL, 8'h0f);
    rd(IDX_CONTROL);
    check(34'(d[4]), 34'h1);
    @(posedge clock_i);
    trip <= 1'b0;
    repeat (4) @(posedge clock_i);
    wr(IDX_CONTROL, 8'h0f);
    rd(IDX_CONTROL);
    check(34'(d[4]), 34'h0);
    repeat (300) @(posedge clock_i);
    wave(win, hi, bad, iq);
    check(34'(hi), 34'(e));
    check(34'(bad), 34'h0);
    @(posedge clock_i);
    trip_hi <= 1'b0;
    trip <= 1'b1;
    wr(IDX_CONTROL, 8'h07);
    wave(win, hi, bad, iq);
    check(34'(hi), 34'(win));
    $display("fault test done");
    wr(IDX_MODULE_ENABLE, 8'h00);
    check({ms, cs}, 34'h0);
    $display("disable test done");
    finish_test();
  end
endmodule : tb_pwm12_fault_lock_unit
